// ---- rtl/dtfr_debug.sv ----
module dtfr_debug
  import dtfr_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire dtfr_bus_t bus,
  input wire logic secure,
  input wire logic trace_begin,
  input wire logic event_only,
  input wire logic trigger_type_select,
  output logic [7:0] rdata,
  output logic break_req,
  output logic break_tag,
  output logic system_reset_req,
  output logic capture_active_flag,
  output logic [3:0] fifo_count
);

  ////////////////////////////////////////////////////////////////////////////
  // decode

  function automatic logic hit(input dtfr_bus_t b, input logic [15:0] a);
    return b.valid && (b.addr == a);
  endfunction : hit

  function automatic logic cmp_match(input dtfr_bus_t b,
                                     input logic [15:0] value,
                                     input logic dir_en,
                                     input logic dir);
    return b.valid && (b.addr == value) && (!dir_en || (b.rnw == dir));
  endfunction : cmp_match

  logic wr;
  logic rd;
  assign wr = bus.valid && !bus.rnw;
  assign rd = bus.valid && bus.rnw;

  dtfr_ctrl_t ctrl_q;
  logic arm_q;
  logic [7:0] cmp_a_high_q;
  logic [7:0] cmp_a_low_q;
  logic [7:0] cmp_b_high_q;
  logic [7:0] cmp_b_low_q;
  logic [15:0] fifo_q [DTFR_DEPTH];
  logic [15:0] last_fetch_q;
  logic [3:0] cnt_q;
  dtfr_run_t run_q;
  dtfr_ctrl_t wctrl;
  assign wctrl = dtfr_ctrl_t'(bus.wdata);

  ////////////////////////////////////////////////////////////////////////////
  // register select strobes, shared by the read mux and the write paths

  logic sel_force;
  logic sel_cah;
  logic sel_cal;
  logic sel_cbh;
  logic sel_cbl;
  logic sel_fh;
  logic sel_fl;
  logic sel_ctrl;
  assign sel_force = hit(bus, ADDR_HOST_FORCED_RESET);
  assign sel_cah = hit(bus, ADDR_CMP_A_HIGH);
  assign sel_cal = hit(bus, ADDR_CMP_A_LOW);
  assign sel_cbh = hit(bus, ADDR_CMP_B_HIGH);
  assign sel_cbl = hit(bus, ADDR_CMP_B_LOW);
  assign sel_fh = hit(bus, ADDR_FIFO_HIGH);
  assign sel_fl = hit(bus, ADDR_FIFO_LOW);
  assign sel_ctrl = hit(bus, ADDR_DEBUG_CONTROL);

  // comparators freeze while armed so a run sees one stable match value
  logic cmp_wr_ok;
  assign cmp_wr_ok = ce && wr && !arm_q;

  // arming needs the enable as well; a secure part gets neither
  function automatic logic arm_grant(input dtfr_ctrl_t c, input logic sec);
    return c.arm && c.module_enable && !sec;
  endfunction : arm_grant

  logic arm_req;
  assign arm_req = arm_grant(wctrl, secure);

  logic [15:0] cmp_a_value;
  logic [15:0] cmp_b_value;
  assign cmp_a_value = {cmp_a_high_q, cmp_a_low_q};
  assign cmp_b_value = {cmp_b_high_q, cmp_b_low_q};

  ////////////////////////////////////////////////////////////////////////////
  // comparators and trigger

  logic match_a;
  logic match_b;
  logic trig_raw;
  logic trig;
  logic begin_mode;
  assign match_a = cmp_match(bus, cmp_a_value,
                             ctrl_q.cmp_a_direction_enable,
                             ctrl_q.cmp_a_direction);
  assign match_b = cmp_match(bus, cmp_b_value,
                             ctrl_q.cmp_b_direction_enable,
                             ctrl_q.cmp_b_direction);
  assign trig_raw = event_only ? match_b : (match_a || match_b);
  // tag type only qualifies which access counts; break timing is untouched
  assign trig = trig_raw && (!trigger_type_select || bus.fetch);
  // event-only modes always behave as begin traces
  assign begin_mode = trace_begin || event_only;

  ////////////////////////////////////////////////////////////////////////////
  // run control

  logic store_evt;
  logic push;
  logic run_done;
  logic ctrl_wr;
  logic adv;
  assign store_evt = event_only ? match_b : bus.fetch;
  assign push = arm_q && store_evt &&
                ((run_q == RUN_FILL) || ((run_q == RUN_WAIT) && trig));
  assign run_done = arm_q &&
                    ((begin_mode && push && (cnt_q == CNT_LAST)) ||
                     (!begin_mode && (run_q == RUN_FILL) && trig));
  assign ctrl_wr = wr && sel_ctrl;
  assign adv = rd && sel_fl && !arm_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= CTRL_RESET;
    end else if (ce && ctrl_wr) begin
      ctrl_q <= wctrl;
      ctrl_q.module_enable <= wctrl.module_enable && !secure;
      // arm state lives in arm_q; the stored copy stays clear
      ctrl_q.arm <= 1'b0;
    end
  end

  // a write setting arm wins over a run ending in the same cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      arm_q <= 1'b0;
    end else if (ce) begin
      if (ctrl_wr) begin
        arm_q <= arm_req;
      end else if (run_done) begin
        arm_q <= 1'b0;
      end
    end
  end

  // run phase: an end trace fills from arming, a begin trace waits
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      run_q <= RUN_IDLE;
    end else if (ce) begin
      if (ctrl_wr) begin
        if (arm_req) begin
          run_q <= begin_mode ? RUN_WAIT : RUN_FILL;
        end else begin
          run_q <= RUN_IDLE;
        end
      end else if (run_done) begin
        run_q <= RUN_IDLE;
      end else begin
        case (run_q)
          RUN_IDLE: begin
            run_q <= RUN_IDLE;
          end
          RUN_WAIT: begin
            if (trig) begin
              run_q <= RUN_FILL;
            end
          end
          RUN_FILL: begin
            run_q <= RUN_FILL;
          end
          default: begin
            run_q <= RUN_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= CNT_ZERO;
    end else if (ce) begin
      if (ctrl_wr && wctrl.arm) begin
        cnt_q <= CNT_ZERO;
      end else if (push && (cnt_q != CNT_FULL)) begin
        cnt_q <= cnt_q + CNT_ONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparator registers

  // one process per byte; all four share the armed write lock
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmp_a_high_q <= BYTE_ZERO;
    end else if (cmp_wr_ok && sel_cah) begin
      cmp_a_high_q <= bus.wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmp_a_low_q <= BYTE_ZERO;
    end else if (cmp_wr_ok && sel_cal) begin
      cmp_a_low_q <= bus.wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmp_b_high_q <= BYTE_ZERO;
    end else if (cmp_wr_ok && sel_cbh) begin
      cmp_b_high_q <= bus.wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmp_b_low_q <= BYTE_ZERO;
    end else if (cmp_wr_ok && sel_cbl) begin
      cmp_b_low_q <= bus.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifo: newest word enters at the last slot, readout from slot 0

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      last_fetch_q <= WORD_ZERO;
    end else if (ce && bus.valid && bus.fetch) begin
      last_fetch_q <= bus.addr;
    end
  end

  logic shift;
  logic [15:0] capture_word;
  logic [15:0] in_word;
  assign shift = push || adv;
  // event-only runs keep just the written byte, full runs the address
  assign capture_word = event_only ? {BYTE_ZERO, bus.wdata}
                                   : bus.addr;
  // unarmed fifo low reads prime the tail, giving an eight-read delay line
  assign in_word = push ? capture_word : last_fetch_q;

  generate
    for (genvar i = 0; i < DTFR_DEPTH; i++) begin : g_fifo
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          fifo_q[i] <= WORD_ZERO;
        end else if (ce && shift) begin
          if (i == DTFR_DEPTH - 1) begin
            fifo_q[i] <= in_word;
          end else begin
            fifo_q[i] <= fifo_q[(i + 1) % DTFR_DEPTH];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read data, registered one cycle after the read

  logic [7:0] rd_d;
  always_comb begin
    // unmapped addresses read zero
    rd_d = BYTE_ZERO;
    if (sel_cah) begin
      rd_d = cmp_a_high_q;
    end
    if (sel_cal) begin
      rd_d = cmp_a_low_q;
    end
    if (sel_cbh) begin
      rd_d = cmp_b_high_q;
    end
    if (sel_cbl) begin
      rd_d = cmp_b_low_q;
    end
    if (sel_fh) begin
      rd_d = event_only ? BYTE_ZERO : fifo_q[0][15:8];
    end
    if (sel_fl) begin
      rd_d = fifo_q[0][7:0];
    end
    if (sel_ctrl) begin
      rd_d = {ctrl_q.module_enable, arm_q, ctrl_q[5:0]};
    end
    if (sel_force) begin
      rd_d = BYTE_ZERO;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata <= BYTE_ZERO;
    end else if (ce && rd) begin
      rdata <= rd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // break request and forced reset, one-cycle pulses

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      break_req <= 1'b0;
    end else if (ce) begin
      break_req <= run_done && ctrl_q.break_request_enable;
    end
  end

  // the type only means something when a break is actually requested
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      break_tag <= 1'b0;
    end else if (ce && run_done && ctrl_q.break_request_enable) begin
      break_tag <= ctrl_q.tag_select;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      system_reset_req <= 1'b0;
    end else if (ce) begin
      // only background commands reach the force-reset bit
      system_reset_req <= wr && bus.bgnd &&
                          hit(bus, ADDR_HOST_FORCED_RESET) &&
                          bus.wdata[FORCE_RESET_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status outputs are plain copies of their flops

  assign capture_active_flag = arm_q;
  assign fifo_count = cnt_q;

endmodule : dtfr_debug

// ---- rtl/dtfr_pkg.sv ----
package dtfr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int unsigned DTFR_DEPTH = 8;
  localparam int unsigned DTFR_AW = 16;
  localparam int unsigned DTFR_DW = 8;
  localparam int unsigned DTFR_FW = 16;

  ////////////////////////////////////////////////////////////////////////////
  // register addresses in the normal memory map
  localparam logic [15:0] ADDR_HOST_FORCED_RESET = 16'h1801;
  localparam logic [15:0] ADDR_CMP_A_HIGH = 16'h1810;
  localparam logic [15:0] ADDR_CMP_A_LOW = 16'h1811;
  localparam logic [15:0] ADDR_CMP_B_HIGH = 16'h1812;
  localparam logic [15:0] ADDR_CMP_B_LOW = 16'h1813;
  localparam logic [15:0] ADDR_FIFO_HIGH = 16'h1814;
  localparam logic [15:0] ADDR_FIFO_LOW = 16'h1815;
  localparam logic [15:0] ADDR_DEBUG_CONTROL = 16'h1816;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and fixed figures
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_LAST = 4'h7;
  localparam logic [3:0] CNT_FULL = 4'h8;
  localparam int unsigned FORCE_RESET_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic valid;
    logic rnw;
    logic fetch;
    logic bgnd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dtfr_bus_t;

  // field order equals bit order 7..0 of debug_control
  typedef struct packed {
    logic module_enable;
    logic arm;
    logic tag_select;
    logic break_request_enable;
    logic cmp_a_direction;
    logic cmp_a_direction_enable;
    logic cmp_b_direction;
    logic cmp_b_direction_enable;
  } dtfr_ctrl_t;

  localparam dtfr_ctrl_t CTRL_RESET = dtfr_ctrl_t'(8'h00);

  typedef enum logic [1:0] {
    RUN_IDLE,
    RUN_WAIT,
    RUN_FILL
  } dtfr_run_t;

endpackage : dtfr_pkg

// ---- tb/dtfr_debug_asserts.sv ----
module dtfr_debug_asserts
  import dtfr_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire dtfr_bus_t bus,
  input wire logic secure,
  input wire logic event_only,
  input wire logic [7:0] rdata,
  input wire logic break_req,
  input wire logic system_reset_req,
  input wire logic capture_active_flag,
  input wire logic [3:0] fifo_count
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic rd, wr, wr_ctl, arm_ok, bg_rst;
  assign rd = ce && bus.valid && bus.rnw;
  assign wr = ce && bus.valid && !bus.rnw;
  assign wr_ctl = wr && bus.addr == ADDR_DEBUG_CONTROL;
  assign arm_ok = wr_ctl && bus.wdata[7:6] == 2'b11 && !secure;
  assign bg_rst = wr && bus.bgnd && bus.wdata[0]
    && bus.addr == ADDR_HOST_FORCED_RESET;
  //////////////////////////////////////////////////////////////////////////
  AST_FORCE_RESET: assert property (bg_rst |=> system_reset_req)
    else $error("no reset pulse after background write");
  AST_RESET_CAUSE: assert property (system_reset_req |-> $past(bg_rst))
    else $error("reset pulse without background write");
  AST_RESET_ONE: assert property (system_reset_req |=> !system_reset_req)
    else $error("reset pulse longer than one cycle");
  AST_FORCE_READ_ZERO: assert property (
    rd && bus.addr == ADDR_HOST_FORCED_RESET |=> rdata == BYTE_ZERO)
    else $error("force reset register read not zero");
  AST_FIFO_HIGH_ZERO: assert property (
    rd && event_only && bus.addr == ADDR_FIFO_HIGH |=> rdata == BYTE_ZERO)
    else $error("fifo high byte not zero in event mode");
  AST_ARM_SET: assert property (arm_ok |=> ##[0:1] capture_active_flag)
    else $error("arm write did not arm");
  AST_ARM_STOP: assert property (
    wr_ctl && bus.wdata[7:6] != 2'b11 |=> ##1 !capture_active_flag)
    else $error("disarm write did not stop run");
  AST_SECURE_ARM: assert property (
    $rose(capture_active_flag) |-> $past(arm_ok) || $past(arm_ok, 2))
    else $error("armed without legal arm write");
  AST_BREAK_END: assert property (break_req |-> $fell(capture_active_flag))
    else $error("break request outside run end");
  AST_COUNT_RANGE: assert property (fifo_count <= CNT_FULL)
    else $error("fifo count above eight");
  C_BREAK: cover property (break_req);
  C_RESET: cover property (system_reset_req);
  C_FULL: cover property ($fell(capture_active_flag) && fifo_count == CNT_FULL);
endmodule : dtfr_debug_asserts

bind dtfr_debug dtfr_debug_asserts u_chk (.mclk(mclk), .rstn(rstn), .ce(ce),
  .bus(bus), .secure(secure), .event_only(event_only), .rdata(rdata),
  .break_req(break_req), .system_reset_req(system_reset_req),
  .capture_active_flag(capture_active_flag), .fifo_count(fifo_count));

// ---- tb/dtfr_host_model.sv ----
module dtfr_host_model
  import dtfr_pkg::*;
(
  input wire logic mclk,
  input wire logic go,
  input wire logic [7:0] data,
  output dtfr_bus_t hbus
);
  timeunit 1ns;
  timeprecision 1ns;
  // one background write per go; idle data inverted so nothing stale passes
  always @(posedge mclk) begin
    hbus <= '{go, 1'b0, 1'b0, 1'b1, ADDR_HOST_FORCED_RESET,
      go ? data : ~data};
  end
endmodule : dtfr_host_model

// ---- tb/testbench.sv ----
module testbench
  import dtfr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, rstn = 1'b0, ce = 1'b1, secure = 1'b0, go = 1'b0;
  logic trace_begin = 1'b0, event_only = 1'b0, trig_type = 1'b0;
  dtfr_bus_t tb_bus = '0, hbus, bus;
  logic [7:0] rdata, d, h;
  logic break_req, break_tag, sys_rst, flag;
  logic [3:0] cnt;
  int failures = 0, checks = 0, n_brk = 0, n_rst = 0, cyc = 0;
  // the host owns the bus only while its write is valid
  assign bus = (hbus.valid === 1'b1) ? hbus : tb_bus;
  always #50 mclk = ~mclk;
  dtfr_debug uut (.mclk(mclk), .rstn(rstn), .ce(ce), .bus(bus),
    .secure(secure), .trace_begin(trace_begin), .event_only(event_only),
    .trigger_type_select(trig_type), .rdata(rdata), .break_req(break_req),
    .break_tag(break_tag), .system_reset_req(sys_rst),
    .capture_active_flag(flag), .fifo_count(cnt));
  dtfr_host_model host (.mclk(mclk), .go(go), .data(8'h01), .hbus(hbus));
  always @(posedge mclk) begin
    cyc++;
    if (break_req === 1'b1) n_brk++;
    if (sys_rst === 1'b1) n_rst++;
    if (cyc == 4000) begin
      failures++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  // sample one edge late so both answer readings of rdata are settled
  task acc(input logic rnw, input logic f, input logic [15:0] a,
    input logic [7:0] w);
    @(posedge mclk) tb_bus <= '{1'b1, rnw, f, 1'b0, a, w};
    @(posedge mclk) tb_bus.valid <= 1'b0;
    @(posedge mclk) d = rdata;
  endtask : acc
  task wr(input logic [15:0] a, input logic [7:0] w);
    acc(1'b0, 1'b0, a, w);
  endtask : wr
  task rd(input logic [15:0] a);
    acc(1'b1, 1'b0, a, 8'h00);
  endtask : rd
  task complete_run;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
    logic [7:0] cv [4];
    cv = '{8'h3c, 8'h5a, 8'h0b, 8'ha5};
    for (int i = 0; i < 4; i++) begin
      rd(ADDR_CMP_A_HIGH + 16'(i));
      chk(d, 16'h0000);
      wr(ADDR_CMP_A_HIGH + 16'(i), cv[i]);
      rd(ADDR_CMP_A_HIGH + 16'(i));
      chk(d, cv[i]);
    end
    wr(ADDR_HOST_FORCED_RESET, 8'hff);
    rd(ADDR_HOST_FORCED_RESET);
    chk(d, 16'h0000);
    chk(n_rst, 0);
    @(posedge mclk) go <= 1'b1;
    @(posedge mclk) go <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(n_rst, 1);
  endtask : t_regs
  task t_profile;
    for (int i = 1; i <= 12; i++) begin
      acc(1'b1, 1'b1, 16'h2000 + 16'(i * 257), 8'h00);
      if (i == 10) wr(ADDR_FIFO_LOW, 8'hee);
      if (i == 10) wr(ADDR_FIFO_HIGH, 8'hee);
      rd(ADDR_FIFO_HIGH);
      h = d;
      rd(ADDR_FIFO_HIGH);
      chk(d, h);
      rd(ADDR_FIFO_LOW);
      if (i > 8) chk({h, d}, 16'h2000 + 16'((i - 8) * 257));
    end
  endtask : t_profile
  task t_armed;
    secure <= 1'b1;
    wr(ADDR_DEBUG_CONTROL, 8'hc0);
    chk(flag, 1'b0);
    secure <= 1'b0;
    trace_begin <= 1'b1;
    wr(ADDR_DEBUG_CONTROL, 8'hc0);
    chk(flag, 1'b1);
    rd(ADDR_DEBUG_CONTROL);
    chk(d, 8'hc0);
    rd(ADDR_FIFO_LOW);
    h = d;
    rd(ADDR_FIFO_LOW);
    chk(d, h);
    wr(ADDR_CMP_A_HIGH, 8'h77);
    rd(ADDR_CMP_A_HIGH);
    chk(d, 8'h3c);
    wr(ADDR_DEBUG_CONTROL, 8'h80);
    chk({flag, 8'(n_brk)}, 16'h0000);
  endtask : t_armed
  task t_end;
    trace_begin <= 1'b0;
    wr(ADDR_DEBUG_CONTROL, 8'hdc);
    for (int i = 0; i < 10; i++) acc(1'b1, 1'b1, 16'h1000 + 16'(i), 8'h00);
    wr(16'h3c5a, 8'h00);
    chk(flag, 1'b1);
    trig_type <= 1'b1;
    rd(16'h3c5a);
    chk(flag, 1'b1);
    acc(1'b1, 1'b1, 16'h3c5a, 8'h00);
    trig_type <= 1'b0;
    chk({flag, break_tag}, 2'b00);
    @(posedge mclk);
    chk(n_brk, 1);
  endtask : t_end
  task t_event;
    event_only <= 1'b1;
    trace_begin <= 1'b1;
    wr(ADDR_DEBUG_CONTROL, 8'hf1);
    rd(16'h0ba5);
    for (int i = 0; i < 8; i++) wr(16'h0ba5, 8'h40 + 8'(i));
    chk({flag, break_tag, cnt}, 6'h18);
    @(posedge mclk);
    chk(n_brk, 2);
    rd(ADDR_FIFO_HIGH);
    chk(d, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      rd(ADDR_FIFO_LOW);
      chk(d, 8'h40 + 8'(i));
    end
  endtask : t_event
  initial begin
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    t_regs();
    t_profile();
    t_armed();
    t_end();
    t_event();
    complete_run();
  end
endmodule : testbench
